/* pkg/gcs_pkg.sv */
package gcs_pkg;

  // ---------------------------------------------------------------
  // register offsets
  // ---------------------------------------------------------------
  localparam logic [6:0] GCS_OFF_IRQ_STATUS = 7'h0A;
  localparam logic [6:0] GCS_OFF_QUEUE_STATUS = 7'h0E;
  localparam logic [6:0] GCS_OFF_FULL_SCALE = 7'h0F;
  localparam logic [6:0] GCS_OFF_RATE_FILTER = 7'h10;
  localparam logic [6:0] GCS_OFF_POWER_STATE = 7'h11;
  localparam logic [6:0] GCS_OFF_SOFT_RESET = 7'h14;
  localparam logic [6:0] GCS_OFF_IRQ_ENABLE = 7'h15;
  localparam logic [6:0] GCS_OFF_QUEUE_CONFIG = 7'h3E;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int GCS_BIT_DRDY = 7;
  localparam int GCS_BIT_QUEUE_INT = 4;
  localparam int GCS_BIT_OVERRUN = 7;
  localparam int GCS_BIT_EN_DRDY = 7;
  localparam int GCS_BIT_EN_QUEUE = 6;
  localparam int GCS_BIT_BW_FIXED = 7;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic [7:0] GCS_RST_FULL_SCALE = 8'h00;
  localparam logic [6:0] GCS_RST_RATE_FILTER = 7'h00;
  localparam logic [7:0] GCS_RST_IRQ_ENABLE = 8'h00;
  localparam logic [7:0] GCS_PM_NORMAL = 8'h00;
  localparam logic [7:0] GCS_PM_SUSPEND = 8'h80;
  localparam logic [7:0] GCS_PM_DEEP = 8'h20;
  localparam logic [7:0] GCS_SRST_KEY = 8'hB6;
  localparam logic [6:0] GCS_QUEUE_DEPTH = 7'h64;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int GCS_CLK_NS = 10;
  localparam int GCS_DRDY_MIN_US = 280;
  localparam int GCS_DRDY_MAX_US = 400;
  localparam int GCS_DRDY_HOLD_CYC = (GCS_DRDY_MIN_US * 1000 + GCS_CLK_NS - 1) / GCS_CLK_NS;
  localparam int GCS_SRST_DELAY_MS = 30;
  localparam int GCS_SRST_DELAY_CYC = (GCS_SRST_DELAY_MS * 1000000 + GCS_CLK_NS - 1) / GCS_CLK_NS;

  // power state, one-hot
  typedef enum logic [2:0] {
    GCS_PS_NORMAL = 3'b001,
    GCS_PS_SUSPEND = 3'b010,
    GCS_PS_DEEP = 3'b100
  } gcs_power_t;

  // soft reset sequencer, one-hot
  typedef enum logic [1:0] {
    GCS_SR_IDLE = 2'b01,
    GCS_SR_WAIT = 2'b10
  } gcs_srst_t;

endpackage

/* rtl/gcs_timer.sv */
`timescale 1ns/1ns
module gcs_timer
  import gcs_pkg::*;
#(
  parameter int CYCLES = 16
)
(
  // clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_start,
  // status
  output logic o_busy,
  output logic o_done
);

  logic [31:0] cnt_r;
  logic busy_r;

  // done fires exactly CYCLES edges after the start edge
  assign o_done = busy_r && (cnt_r == 32'h00000001) && !i_start;
  assign o_busy = busy_r;

  // a fresh start reloads, so a new event restarts the whole interval
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cnt_r <= 32'h00000000;
      busy_r <= 1'b0;
    end
    else if (i_start)
    begin
      cnt_r <= 32'(CYCLES);
      busy_r <= 1'b1;
    end
    else if (busy_r)
    begin
      cnt_r <= cnt_r - 32'h00000001;
      busy_r <= (cnt_r != 32'h00000001);
    end
  end

endmodule

/* rtl/gcs_regs.sv */
// Notes on behaviour
// - status register: new-sample flag bit 7, queue flag bit 4, others zero.
// - new-sample flag clears itself 280 to 400 us after being set.
// - overrun flag at bit 7 is sticky; only a queue configuration write clears it.
// - queue status bits 6:0 show frames held; empty reads zero.
// - fill level returns to zero when drained or on queue configuration write.
// - bandwidth code 0..7 selects output rate and filter bandwidth pairs.
// - bandwidth bit 7 reads one, ignores writes; register resets to 0x80.
// - power codes: 0x00 normal, 0x80 suspend, 0x20 deep suspend; resets normal.
// - soft reset starts only on writing 0xB6; other values do nothing.
// - 30 ms after accepted soft reset, configuration registers return to reset values.
// - soft reset is accepted in every power mode.
// - new-sample interrupt raised per sample only while enable bit 7 is set.
// - queue interrupt raised only while enable bit 6 set; bits 5:0 reserved.
`timescale 1ns/1ns
module gcs_regs
  import gcs_pkg::*;
#(
  parameter int P_DRDY_HOLD_CYC = GCS_DRDY_HOLD_CYC,
  parameter int P_SRST_DELAY_CYC = GCS_SRST_DELAY_CYC
)
(
  // clock and reset
  input wire logic I_MCLK,
  input wire logic I_NRST,
  // register port
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  input wire logic [6:0] I_ADDR,
  input wire logic [7:0] I_WDATA,
  output logic [7:0] O_RDATA,
  output logic O_RVALID,
  // sensor core events
  input wire logic I_SAMPLE_STB,
  input wire logic I_QUEUE_PUSH,
  input wire logic I_QUEUE_POP,
  input wire logic I_QUEUE_COND,
  // interrupt requests
  output logic O_DRDY_IRQ,
  output logic O_QUEUE_IRQ,
  // configuration towards the sensor core
  output logic [10:0] O_FULL_SCALE_DPS,
  output logic [10:0] O_OUTPUT_SAMPLE_RATE,
  output logic [9:0] O_FILTER_BW_HZ,
  output gcs_power_t O_POWER_STATE,
  output logic O_QUEUE_CLEAR,
  output logic O_SRST_BUSY,
  // queue status
  output logic [6:0] O_QUEUE_LEVEL,
  output logic O_QUEUE_OVERRUN
);

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [6:0] addr, input logic [6:0] off);
    hit = (addr == off);
  endfunction

  logic wr_range, wr_bw, wr_pm, wr_srst, wr_ctrl, wr_qcfg;
  assign wr_range = I_WR_EN && hit(I_ADDR, GCS_OFF_FULL_SCALE);
  assign wr_bw = I_WR_EN && hit(I_ADDR, GCS_OFF_RATE_FILTER);
  assign wr_pm = I_WR_EN && hit(I_ADDR, GCS_OFF_POWER_STATE);
  assign wr_srst = I_WR_EN && hit(I_ADDR, GCS_OFF_SOFT_RESET);
  assign wr_ctrl = I_WR_EN && hit(I_ADDR, GCS_OFF_IRQ_ENABLE);
  assign wr_qcfg = I_WR_EN && hit(I_ADDR, GCS_OFF_QUEUE_CONFIG);

  // ---------------------------------------------------------------
  // soft reset sequencer
  // ---------------------------------------------------------------
  gcs_srst_t srst_r, srst_nxt;
  logic srst_key, srst_done;

  // no power-mode term: the key works in every mode
  assign srst_key = wr_srst && (I_WDATA == GCS_SRST_KEY);

  gcs_timer #(.CYCLES(P_SRST_DELAY_CYC)) u_srst_timer (
    .i_clk(I_MCLK),
    .i_nrst(I_NRST),
    .i_start(srst_key),
    .o_busy(),
    .o_done(srst_done)
  );

  always_comb
  begin
    srst_nxt = srst_r;
    unique case (srst_r)
      GCS_SR_IDLE: if (srst_key) srst_nxt = GCS_SR_WAIT;
      GCS_SR_WAIT: if (srst_done) srst_nxt = GCS_SR_IDLE;
    endcase
  end

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      srst_r <= GCS_SR_IDLE;
    else
      srst_r <= srst_nxt;
  end

  assign O_SRST_BUSY = (srst_r == GCS_SR_WAIT);

  // ---------------------------------------------------------------
  // configuration registers
  // ---------------------------------------------------------------
  logic [7:0] range_r, ctrl_r, pm_r;
  logic [6:0] bw_r;
  logic pm_legal;

  // unknown power codes are dropped so the mode always stays defined
  assign pm_legal = (I_WDATA == GCS_PM_NORMAL) || (I_WDATA == GCS_PM_SUSPEND) || (I_WDATA == GCS_PM_DEEP);

  // pin reset stays purely asynchronous; the delayed reset is a synchronous branch
  // and a late host write loses to it in the same cycle
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      range_r <= GCS_RST_FULL_SCALE;
      bw_r <= GCS_RST_RATE_FILTER;
      pm_r <= GCS_PM_NORMAL;
      ctrl_r <= GCS_RST_IRQ_ENABLE;
    end
    else if (srst_done)
    begin
      range_r <= GCS_RST_FULL_SCALE;
      bw_r <= GCS_RST_RATE_FILTER;
      pm_r <= GCS_PM_NORMAL;
      ctrl_r <= GCS_RST_IRQ_ENABLE;
    end
    else
    begin
      if (wr_range) range_r <= I_WDATA;
      if (wr_bw) bw_r <= I_WDATA[6:0];
      if (wr_pm && pm_legal) pm_r <= I_WDATA;
      if (wr_ctrl) ctrl_r <= {I_WDATA[7:6], 6'h00};
    end
  end

  // ---------------------------------------------------------------
  // decoded settings
  // ---------------------------------------------------------------
  function automatic logic [10:0] scale_of(input logic [7:0] code);
    unique case (code)
      8'h01: scale_of = 11'h3E8;
      8'h02: scale_of = 11'h1F4;
      8'h03: scale_of = 11'h0FA;
      8'h04: scale_of = 11'h07D;
      default: scale_of = 11'h7D0;
    endcase
  endfunction

  // rate in bits 20:10, filter bandwidth in bits 9:0
  function automatic logic [20:0] rate_of(input logic [6:0] code);
    unique case (code)
      7'h01: rate_of = {11'h7D0, 10'h0E6};
      7'h02: rate_of = {11'h3E8, 10'h074};
      7'h03: rate_of = {11'h190, 10'h02F};
      7'h04: rate_of = {11'h0C8, 10'h017};
      7'h05: rate_of = {11'h064, 10'h00C};
      7'h06: rate_of = {11'h0C8, 10'h040};
      7'h07: rate_of = {11'h064, 10'h020};
      default: rate_of = {11'h7D0, 10'h214};
    endcase
  endfunction

  logic [20:0] rate_sel;
  gcs_power_t ps_sel;
  assign rate_sel = rate_of(bw_r);
  assign ps_sel = (pm_r == GCS_PM_SUSPEND) ? GCS_PS_SUSPEND :
                  (pm_r == GCS_PM_DEEP) ? GCS_PS_DEEP : GCS_PS_NORMAL;

  // settings leave through flops, one cycle behind the registers
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_FULL_SCALE_DPS <= 11'h7D0;
      O_OUTPUT_SAMPLE_RATE <= 11'h7D0;
      O_FILTER_BW_HZ <= 10'h214;
      O_POWER_STATE <= GCS_PS_NORMAL;
    end
    else
    begin
      O_FULL_SCALE_DPS <= scale_of(range_r);
      O_OUTPUT_SAMPLE_RATE <= rate_sel[20:10];
      O_FILTER_BW_HZ <= rate_sel[9:0];
      O_POWER_STATE <= ps_sel;
    end
  end

  // ---------------------------------------------------------------
  // new-sample flag
  // ---------------------------------------------------------------
  logic drdy_r, drdy_set, drdy_done;
  assign drdy_set = I_SAMPLE_STB && ctrl_r[GCS_BIT_EN_DRDY];

  gcs_timer #(.CYCLES(P_DRDY_HOLD_CYC)) u_drdy_timer (
    .i_clk(I_MCLK),
    .i_nrst(I_NRST),
    .i_start(drdy_set),
    .o_busy(),
    .o_done(drdy_done)
  );

  // a new sample wins over the timed clear and restarts the hold
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      drdy_r <= 1'b0;
    else if (drdy_set)
      drdy_r <= 1'b1;
    else if (drdy_done)
      drdy_r <= 1'b0;
  end

  assign O_DRDY_IRQ = drdy_r;
  assign O_QUEUE_IRQ = I_QUEUE_COND && ctrl_r[GCS_BIT_EN_QUEUE];

  // ---------------------------------------------------------------
  // queue status
  // ---------------------------------------------------------------
  logic [6:0] level_r;
  logic ovr_r, q_full, q_ovr;
  assign q_full = (level_r == GCS_QUEUE_DEPTH);
  assign q_ovr = I_QUEUE_PUSH && !I_QUEUE_POP && q_full;
  assign O_QUEUE_CLEAR = wr_qcfg;

  // draining to zero happens through pops; a config write empties at once
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      level_r <= 7'h00;
    else if (wr_qcfg)
      level_r <= 7'h00;
    else if (I_QUEUE_PUSH && !I_QUEUE_POP && !q_full)
      level_r <= level_r + 7'h01;
    else if (I_QUEUE_POP && !I_QUEUE_PUSH && (level_r != 7'h00))
      level_r <= level_r - 7'h01;
  end

  // overrun arriving with the clearing write is kept
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      ovr_r <= 1'b0;
    else if (q_ovr)
      ovr_r <= 1'b1;
    else if (wr_qcfg)
      ovr_r <= 1'b0;
  end

  assign O_QUEUE_LEVEL = level_r;
  assign O_QUEUE_OVERRUN = ovr_r;

  // ---------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------
  logic [7:0] rd_mux, stat_val;
  assign stat_val = {drdy_r, 2'b00, O_QUEUE_IRQ, 4'h0};
  assign rd_mux = hit(I_ADDR, GCS_OFF_IRQ_STATUS) ? stat_val :
                  hit(I_ADDR, GCS_OFF_QUEUE_STATUS) ? {ovr_r, level_r} :
                  hit(I_ADDR, GCS_OFF_FULL_SCALE) ? range_r :
                  hit(I_ADDR, GCS_OFF_RATE_FILTER) ? {1'b1, bw_r} :
                  hit(I_ADDR, GCS_OFF_POWER_STATE) ? pm_r :
                  hit(I_ADDR, GCS_OFF_IRQ_ENABLE) ? ctrl_r : 8'h00;

  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
    begin
      O_RDATA <= 8'h00;
      O_RVALID <= 1'b0;
    end
    else
    begin
      O_RVALID <= I_RD_EN;
      if (I_RD_EN) O_RDATA <= rd_mux;
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  logic [31:0] drdy_age_r;
  always_ff @(posedge I_MCLK or negedge I_NRST)
  begin
    if (!I_NRST)
      drdy_age_r <= 32'h00000000;
    else if (drdy_set || !drdy_r)
      drdy_age_r <= 32'h00000000;
    else
      drdy_age_r <= drdy_age_r + 32'h00000001;
  end

  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_NRST);

  a_stat_reserved: assert property (I_RD_EN && hit(I_ADDR, GCS_OFF_IRQ_STATUS) |=>
    O_RDATA[6:5] == 2'b00 && O_RDATA[3:0] == 4'h0 && O_RDATA[7] == $past(drdy_r)) else $error("status reserved bits");
  a_drdy_hold_max: assert property (drdy_r |-> drdy_age_r < 32'(P_DRDY_HOLD_CYC))
    else $error("sample flag held too long");
  a_drdy_hold_min: assert property ($fell(drdy_r) |-> $past(drdy_age_r) == 32'(P_DRDY_HOLD_CYC - 1))
    else $error("sample flag cleared early");
  a_ovr_sticky: assert property (ovr_r && !wr_qcfg |=> ovr_r) else $error("overrun lost");
  a_ovr_sets: assert property (q_ovr |=> ovr_r) else $error("overrun not set");
  a_level_read: assert property (I_RD_EN && hit(I_ADDR, GCS_OFF_QUEUE_STATUS) |=>
    O_RDATA == {$past(ovr_r), $past(level_r)}) else $error("queue status read wrong");
  a_level_clear: assert property (wr_qcfg |=> level_r == 7'h00) else $error("level not cleared");
  a_bw_top_bit: assert property (I_RD_EN && hit(I_ADDR, GCS_OFF_RATE_FILTER) |=> O_RDATA[7])
    else $error("bandwidth bit 7 not one");
  a_pm_decode: assert property (wr_pm && I_WDATA == GCS_PM_DEEP && !srst_done |=> ##1 O_POWER_STATE == GCS_PS_DEEP)
    else $error("deep suspend not selected");
  a_key_only: assert property (srst_r == GCS_SR_IDLE && wr_srst && I_WDATA != GCS_SRST_KEY |=>
    srst_r == GCS_SR_IDLE) else $error("soft reset without key");
  a_key_any_mode: assert property (srst_key |=> O_SRST_BUSY) else $error("key not accepted");
  a_srst_restore: assert property (srst_done |=> range_r == GCS_RST_FULL_SCALE && bw_r == GCS_RST_RATE_FILTER &&
    pm_r == GCS_PM_NORMAL && ctrl_r == GCS_RST_IRQ_ENABLE) else $error("config not restored");
  a_drdy_gate: assert property ($rose(drdy_r) |-> $past(ctrl_r[GCS_BIT_EN_DRDY])) else $error("sample flag ungated");
  a_queue_gate: assert property (!ctrl_r[GCS_BIT_EN_QUEUE] |-> !O_QUEUE_IRQ) else $error("queue irq ungated");

  c_drdy_cycle: cover property ($rose(drdy_r) ##[1:1000] $fell(drdy_r));
  c_srst_done: cover property (srst_done);
  c_overrun: cover property ($rose(ovr_r));
  c_deep: cover property (O_POWER_STATE == GCS_PS_DEEP);

endmodule

/* testbench/gcs_host_model.sv */
`timescale 1ns/1ns
module gcs_host_model
  import gcs_pkg::*;
(
  // clock
  input wire logic i_clk,
  // register port
  output logic o_wr_en,
  output logic o_rd_en,
  output logic [6:0] o_addr,
  output logic [7:0] o_wdata,
  input wire logic [7:0] i_rdata,
  input wire logic i_rvalid
);
  // last power code requested, so suspend swaps can be routed through normal
  logic [7:0] pm_r;

  // idle bus at time zero
  initial
  begin
    o_wr_en = 1'b0;
    o_rd_en = 1'b0;
    o_addr = 7'h7F;
    o_wdata = 8'hFF;
    pm_r = GCS_PM_NORMAL;
  end

  // ---------------------------------------------------------------
  // bus cycles, launched and released on falling edges
  // ---------------------------------------------------------------
  // address and data are inverted after release so stale values never look valid
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(negedge i_clk);
    o_wr_en = 1'b1;
    o_addr = a;
    o_wdata = d;
    @(negedge i_clk);
    o_wr_en = 1'b0;
    o_addr = ~a;
    o_wdata = ~d;
    if (a == GCS_OFF_SOFT_RESET && d == GCS_SRST_KEY)
      pm_r = GCS_PM_NORMAL;
  endtask

  // valid must stand right after the strobe edge; a late answer reads as unknown
  task automatic rd(input logic [6:0] a, output logic [7:0] d);
    @(negedge i_clk);
    o_rd_en = 1'b1;
    o_addr = a;
    @(negedge i_clk);
    o_rd_en = 1'b0;
    o_addr = ~a;
    d = (i_rvalid === 1'b1) ? i_rdata : 8'hXX;
  endtask

  // never swap suspend and deep suspend directly
  task automatic set_pm(input logic [7:0] d);
    if (pm_r != GCS_PM_NORMAL && d != GCS_PM_NORMAL && d != pm_r)
      wr(GCS_OFF_POWER_STATE, GCS_PM_NORMAL);
    wr(GCS_OFF_POWER_STATE, d);
    pm_r = d;
  endtask
endmodule

/* testbench/gyro_control_status_regs_test.sv */
`timescale 1ns/1ns
module gyro_control_status_regs_test
  import gcs_pkg::*;
;
  // short counts keep the run brief; expectations derive from these
  localparam int HOLD = 20;
  localparam int SRST = 50;
  logic mclk = 1'b0;
  logic nrst = 1'b0;
  logic wr_en, rd_en, rvalid;
  logic [6:0] addr;
  logic [7:0] wdata, rdata, rv;
  logic stb = 1'b0, push = 1'b0, pop = 1'b0, cond = 1'b0;
  logic drdy, qirq, qclr, busy, ovr;
  logic [10:0] fs, osr;
  logic [9:0] bw;
  logic [6:0] qlvl;
  gcs_power_t ps;
  int error_cnt = 0;
  int checked = 0;
  logic [10:0] fs_tab [5] = '{11'h7D0, 11'h3E8, 11'h1F4, 11'h0FA, 11'h07D};
  logic [10:0] osr_tab [8] = '{11'h7D0, 11'h7D0, 11'h3E8, 11'h190, 11'h0C8, 11'h064, 11'h0C8, 11'h064};
  logic [10:0] bw_tab [8] = '{11'h214, 11'h0E6, 11'h074, 11'h02F, 11'h017, 11'h00C, 11'h040, 11'h020};

  // free-running clock
  initial
  begin
    forever #5 mclk = ~mclk;
  end

  gcs_regs #(.P_DRDY_HOLD_CYC(HOLD), .P_SRST_DELAY_CYC(SRST)) uut (.I_MCLK(mclk), .I_NRST(nrst),
    .I_WR_EN(wr_en), .I_RD_EN(rd_en), .I_ADDR(addr), .I_WDATA(wdata), .O_RDATA(rdata), .O_RVALID(rvalid),
    .I_SAMPLE_STB(stb), .I_QUEUE_PUSH(push), .I_QUEUE_POP(pop), .I_QUEUE_COND(cond),
    .O_DRDY_IRQ(drdy), .O_QUEUE_IRQ(qirq), .O_FULL_SCALE_DPS(fs), .O_OUTPUT_SAMPLE_RATE(osr),
    .O_FILTER_BW_HZ(bw), .O_POWER_STATE(ps), .O_QUEUE_CLEAR(qclr), .O_SRST_BUSY(busy),
    .O_QUEUE_LEVEL(qlvl), .O_QUEUE_OVERRUN(ovr));

  gcs_host_model host (.i_clk(mclk), .o_wr_en(wr_en), .o_rd_en(rd_en), .o_addr(addr), .o_wdata(wdata),
    .i_rdata(rdata), .i_rvalid(rvalid));

  // ---------------------------------------------------------------
  // compare helpers
  // ---------------------------------------------------------------
  task automatic chk_out(input logic [10:0] got, input logic [10:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [6:0] a, input logic [7:0] exp);
    host.rd(a, rv);
    chk_out({3'h0, rv}, {3'h0, exp});
  endtask

  task automatic step(input int n);
    repeat (n) @(negedge mclk);
  endtask

  task automatic report_and_stop;
    if (error_cnt == 0 && checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_and_tables;
    chk_out({8'h00, ps}, 11'h001);
    chk_reg(GCS_OFF_RATE_FILTER, 8'h80);
    chk_reg(GCS_OFF_IRQ_ENABLE, 8'h00);
    chk_reg(GCS_OFF_QUEUE_STATUS, 8'h00);
    host.wr(GCS_OFF_IRQ_STATUS, 8'hFF);
    chk_reg(GCS_OFF_IRQ_STATUS, 8'h00);
    chk_reg(7'h0C, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      if (i < 5)
      begin
        host.wr(GCS_OFF_FULL_SCALE, i[7:0]);
        step(1);
        chk_out(fs, fs_tab[i]);
        chk_reg(GCS_OFF_FULL_SCALE, i[7:0]);
      end
      host.wr(GCS_OFF_RATE_FILTER, i[7:0]);
      step(1);
      chk_out(osr, osr_tab[i]);
      chk_out({1'b0, bw}, bw_tab[i]);
      chk_reg(GCS_OFF_RATE_FILTER, 8'h80 | i[7:0]);
    end
  endtask

  // deep suspend is reached through normal; odd codes must be ignored
  task automatic t_power;
    host.set_pm(GCS_PM_SUSPEND);
    step(1);
    chk_out({8'h00, ps}, 11'h002);
    host.set_pm(GCS_PM_DEEP);
    step(1);
    chk_out({8'h00, ps}, 11'h004);
    host.wr(GCS_OFF_POWER_STATE, 8'h40);
    chk_reg(GCS_OFF_POWER_STATE, 8'h20);
    host.set_pm(GCS_PM_NORMAL);
    step(1);
    chk_out({8'h00, ps}, 11'h001);
  endtask

  task automatic t_irq;
    stb = 1'b1;
    step(1);
    stb = 1'b0;
    chk_out({10'h000, drdy}, 11'h000);
    host.wr(GCS_OFF_IRQ_ENABLE, 8'hFF);
    chk_reg(GCS_OFF_IRQ_ENABLE, 8'hC0);
    stb = 1'b1;
    step(1);
    stb = 1'b0;
    chk_reg(GCS_OFF_IRQ_STATUS, 8'h80);
    stb = 1'b1;
    step(1);
    stb = 1'b0;
    chk_out({10'h000, drdy}, 11'h001);
    step(HOLD - 1);
    chk_out({10'h000, drdy}, 11'h001);
    step(1);
    chk_out({10'h000, drdy}, 11'h000);
    cond = 1'b1;
    #1;
    chk_out({10'h000, qirq}, 11'h001);
    chk_reg(GCS_OFF_IRQ_STATUS, 8'h10);
    host.wr(GCS_OFF_IRQ_ENABLE, 8'h80);
    chk_out({10'h000, qirq}, 11'h000);
    cond = 1'b0;
  endtask

  // fill past the 100-frame depth so the overrun flag must latch
  task automatic t_queue;
    push = 1'b1;
    step(3);
    push = 1'b0;
    chk_reg(GCS_OFF_QUEUE_STATUS, 8'h03);
    pop = 1'b1;
    step(3);
    pop = 1'b0;
    step(1);
    chk_out({4'h0, qlvl}, 11'h000);
    push = 1'b1;
    step(101);
    push = 1'b0;
    chk_reg(GCS_OFF_QUEUE_STATUS, 8'hE4);
    pop = 1'b1;
    step(1);
    pop = 1'b0;
    step(1);
    chk_out({3'h0, ovr, qlvl}, 11'h0E3);
    fork
      host.wr(GCS_OFF_QUEUE_CONFIG, 8'h00);
      begin
        @(negedge mclk);
        #1;
        chk_out({10'h000, qclr}, 11'h001);
      end
    join
    step(1);
    chk_out({3'h0, ovr, qlvl}, 11'h000);
  endtask

  // key accepted from both suspend modes; config returns to reset only at the delay's end
  task automatic t_soft_reset;
    host.wr(GCS_OFF_FULL_SCALE, 8'h03);
    host.wr(GCS_OFF_RATE_FILTER, 8'h05);
    host.set_pm(GCS_PM_SUSPEND);
    host.wr(GCS_OFF_SOFT_RESET, 8'hB5);
    step(SRST + 2);
    chk_out({10'h000, busy}, 11'h000);
    chk_reg(GCS_OFF_FULL_SCALE, 8'h03);
    host.wr(GCS_OFF_SOFT_RESET, GCS_SRST_KEY);
    step(SRST - 1);
    chk_out({7'h00, busy, ps}, 11'h00A);
    step(1);
    chk_out({10'h000, busy}, 11'h000);
    step(1);
    chk_out({8'h00, ps}, 11'h001);
    chk_reg(GCS_OFF_FULL_SCALE, 8'h00);
    chk_reg(GCS_OFF_RATE_FILTER, 8'h80);
    chk_reg(GCS_OFF_IRQ_ENABLE, 8'h00);
    chk_reg(GCS_OFF_POWER_STATE, 8'h00);
    host.set_pm(GCS_PM_DEEP);
    host.wr(GCS_OFF_SOFT_RESET, GCS_SRST_KEY);
    step(SRST + 1);
    chk_out({7'h00, busy, ps}, 11'h001);
  endtask

  // main sequence
  initial
  begin
    step(10);
    nrst = 1'b1;
    t_reset_and_tables();
    t_power();
    t_irq();
    t_queue();
    t_soft_reset();
    report_and_stop();
  end

  // the sequence needs about 430 cycles; allow over forty times that
  initial
  begin
    #200000;
    error_cnt++;
    report_and_stop();
  end
endmodule
